// *** hdl/multi_write_pkg.sv ***
/*
 * Shared constants for the extended multiple-sector write command block:
 * register byte offsets, field positions, opcodes, reset values, states.
 * Assumes a 32-bit Avalon-MM slave port with byte addresses.
 */
package multi_write_pkg;
    // Byte offsets on the register bus
    localparam logic [5:0] OFS_DATA = 6'h00;
    // Paired taskfile registers: count, lba low, lba mid, lba high
    localparam logic [5:0] PAIR_OFS [0:3] = '{6'h04, 6'h08, 6'h0c, 6'h10};
    localparam logic [5:0] OFS_DRIVE = 6'h14;
    localparam logic [5:0] OFS_COMMAND = 6'h18;
    localparam logic [5:0] OFS_STATE = 6'h1c;
    localparam logic [5:0] OFS_FAULT = 6'h20;
    localparam logic [5:0] OFS_DEVCTL = 6'h24;
    localparam logic [5:0] OFS_BLOCK = 6'h28;
    localparam logic [5:0] OFS_IRQ_STS = 6'h2c;
    localparam logic [5:0] OFS_IRQ_MASK = 6'h30;

    localparam logic [7:0] OP_MULTI_EXT = 8'h39;
    localparam logic [7:0] OP_MULTI_FORCE_EXT = 8'hce;

    // State report fields
    localparam int BUSY_POS = 7;
    localparam int READY_POS = 6;
    localparam int DEVFAULT_POS = 5;
    localparam int SEEKDONE_POS = 4;
    localparam int DATAREQ_POS = 3;
    localparam int CORRECTED_POS = 2;
    localparam int ERRSUM_POS = 0;
    // Fault report fields
    localparam int IDNF_POS = 4;
    localparam int ABORT_POS = 2;
    // Device control field
    localparam int HIGHSEL_POS = 7;
    // Interrupt status / mask fields
    localparam int IRQ_BLOCK_POS = 0;
    localparam int IRQ_DONE_POS = 1;
    localparam int IRQ_FAULT_POS = 2;

    localparam logic [7:0] DRIVE_RESET = 8'h00;
    localparam logic [7:0] BLOCK_RESET = 8'h01;
    localparam logic [2:0] MASK_RESET = 3'h0;
    localparam int SECTOR_WORDS = 256;
    localparam logic [16:0] FULL_COUNT = 17'h10000;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_XFER = 3'h2,
        ST_COMMIT = 3'h4
    } state_t;
endpackage

// *** hdl/byte_pair_reg.sv ***
/*
 * One taskfile register with current and previous halves.
 * A host write pushes the current byte into the previous half; the
 * device may load both halves at once. Read view follows highSel.
 */
module byte_pair_reg (
    input wire logic clk,
    input wire logic srst,
    input wire logic wrEn,
    input wire logic [7:0] wrData,
    input wire logic loadEn,
    input wire logic [7:0] loadCur,
    input wire logic [7:0] loadPrev,
    input wire logic highSel,
    output logic [7:0] rdData,
    output logic [7:0] curByte,
    output logic [7:0] prevByte
);
    logic [7:0] cur_q;
    logic [7:0] prev_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            cur_q <= 8'h00;
            prev_q <= 8'h00;
        end else if (loadEn) begin
            cur_q <= loadCur;
            prev_q <= loadPrev;
        end else if (wrEn) begin
            prev_q <= cur_q;
            cur_q <= wrData;
        end
    end

    assign curByte = cur_q;
    assign prevByte = prev_q;
    assign rdData = highSel ? prev_q : cur_q;
endmodule

// *** hdl/ext_multi_sector_write_cmd.sv ***
/*
 * Command engine for the extended multiple-sector write and its
 * forced-media-write variant, with Avalon-MM register slave and a
 * word stream towards the media side.
 * Assumes the media side accepts words on mediaReady, reports commit
 * completion with mediaCommitDone and failures with mediaFail.
 * // Operation
 * // Opcode 39h takes sectors, then commits media
 * // One interrupt per block, not per sector
 * // Payload moves as 16-bit words
 * // Host: count low current, high previous
 * // Zero count means 65,536 sectors
 * // Error address low bytes when select clear
 * // Error address high bytes when select set
 * // Forced variant commits media before ending status
 * // Forced variant otherwise same as plain
 * // Host: address bytes in current/previous halves
 * // Only id-not-found, aborted; busy/fault/corrected clear
 */
module ext_multi_sector_write_cmd #(
    parameter int SECTOR_LEN = multi_write_pkg::SECTOR_WORDS
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic irq,
    output logic [15:0] mediaWord,
    output logic mediaValid,
    input wire logic mediaReady,
    output logic [47:0] mediaLba,
    output logic mediaCommit,
    output logic mediaForce,
    input wire logic mediaCommitDone,
    input wire logic mediaFail,
    input wire logic mediaFailIdn,
    input wire logic writeCacheEn
);
    localparam int WCW = $clog2(SECTOR_LEN);

    multi_write_pkg::state_t state_q;
    logic rdDone_q;
    logic [31:0] readdata_q;
    logic [7:0] drive_q;
    logic [7:0] block_q;
    logic highSel_q;
    logic [2:0] irqSts_q;
    logic [2:0] irqMask_q;
    logic force_q;
    logic [16:0] remaining_q;
    logic [47:0] lba_q;
    logic [WCW-1:0] wordCnt_q;
    logic [7:0] blkCnt_q;
    logic [15:0] mediaWord_q;
    logic mediaValid_q;
    logic [47:0] mediaLba_q;
    logic mediaCommit_q;
    logic errSum_q;
    logic idnf_q;
    logic abort_q;
    logic [47:0] failLba_q;
    logic errHeld_q;

    logic dataStall;
    logic wrAcc;
    logic rdAcc;
    logic dataTake;
    logic cmdTake;
    logic sectorEnd;
    logic lastSector;
    logic blockEnd;
    logic commitOk;
    logic failNow;
    logic blockEvt;
    logic doneEvt;
    logic faultEvt;
    logic [7:0] blkLen;
    logic [15:0] countFull;
    logic [3:0] pairWr;
    logic [7:0] pairRd [0:3];
    logic [7:0] pairCur [0:3];
    logic [7:0] pairPrev [0:3];
    logic [7:0] stateByte;
    logic [7:0] faultByte;
    logic [7:0] rdMux;

    function automatic logic hit(input logic [5:0] addr, input logic [5:0] ofs);
        hit = (addr[5:2] == ofs[5:2]);
    endfunction

    // Data writes stall only while the previous word is still unclaimed
    assign dataStall = write && hit(address, multi_write_pkg::OFS_DATA) && mediaValid_q && !mediaReady;
    assign waitrequest = (read && !rdDone_q) || dataStall;
    assign wrAcc = write && !dataStall;
    assign rdAcc = read && !rdDone_q;

    assign dataTake = wrAcc && hit(address, multi_write_pkg::OFS_DATA) && (byteenable[1:0] == 2'h3)
        && (state_q == multi_write_pkg::ST_XFER);
    assign cmdTake = wrAcc && hit(address, multi_write_pkg::OFS_COMMAND) && byteenable[0]
        && (state_q == multi_write_pkg::ST_IDLE);

    // Block length of zero behaves as one sector per block
    assign blkLen = (block_q == 8'h00) ? 8'h01 : block_q;
    assign sectorEnd = dataTake && (wordCnt_q == WCW'(SECTOR_LEN - 1));
    assign lastSector = (remaining_q == 17'h00001);
    assign blockEnd = sectorEnd && ((blkCnt_q + 8'h01 == blkLen) || lastSector);
    // Plain write may end on cache acceptance; forced write waits for media
    assign commitOk = (!force_q && writeCacheEn) || mediaCommitDone;
    assign failNow = mediaFail && (state_q != multi_write_pkg::ST_IDLE);

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pair
            logic loadEn;
            logic [7:0] loadCur;
            logic [7:0] loadPrev;
            assign pairWr[gi] = wrAcc && hit(address, multi_write_pkg::PAIR_OFS[gi]) && byteenable[0];
            if (gi == 0) begin : g_count
                assign loadEn = 1'b0;
                assign loadCur = 8'h00;
                assign loadPrev = 8'h00;
            end else begin : g_lba
                // Failing address lands low bytes current, high bytes previous
                assign loadEn = failNow;
                assign loadCur = lba_q[8*(gi-1) +: 8];
                assign loadPrev = lba_q[24+8*(gi-1) +: 8];
            end
            byte_pair_reg u_pair (
                .clk(ref_clk),
                .srst(srst),
                .wrEn(pairWr[gi]),
                .wrData(writedata[7:0]),
                .loadEn(loadEn),
                .loadCur(loadCur),
                .loadPrev(loadPrev),
                .highSel(highSel_q),
                .rdData(pairRd[gi]),
                .curByte(pairCur[gi]),
                .prevByte(pairPrev[gi])
            );
        end
    endgenerate

    assign countFull = {pairPrev[0], pairCur[0]};

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_q <= multi_write_pkg::ST_IDLE;
        end else begin
            case (state_q)
                multi_write_pkg::ST_IDLE: begin
                    if (cmdTake && (writedata[7:0] == multi_write_pkg::OP_MULTI_EXT
                        || writedata[7:0] == multi_write_pkg::OP_MULTI_FORCE_EXT)) begin
                        state_q <= multi_write_pkg::ST_XFER;
                    end
                end
                multi_write_pkg::ST_XFER: begin
                    if (failNow) begin
                        state_q <= multi_write_pkg::ST_IDLE;
                    end else if (sectorEnd && lastSector) begin
                        state_q <= multi_write_pkg::ST_COMMIT;
                    end
                end
                multi_write_pkg::ST_COMMIT: begin
                    if (failNow || commitOk) begin
                        state_q <= multi_write_pkg::ST_IDLE;
                    end
                end
                default: state_q <= multi_write_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            force_q <= 1'b0;
            remaining_q <= 17'h00000;
            lba_q <= 48'h000000000000;
            wordCnt_q <= '0;
            blkCnt_q <= 8'h00;
        end else if (cmdTake) begin
            force_q <= (writedata[7:0] == multi_write_pkg::OP_MULTI_FORCE_EXT);
            // Zero in the full 16-bit count asks for the maximum transfer
            remaining_q <= (countFull == 16'h0000) ? multi_write_pkg::FULL_COUNT : {1'b0, countFull};
            lba_q <= {pairPrev[3], pairPrev[2], pairPrev[1], pairCur[3], pairCur[2], pairCur[1]};
            wordCnt_q <= '0;
            blkCnt_q <= 8'h00;
        end else if (sectorEnd) begin
            wordCnt_q <= '0;
            remaining_q <= remaining_q - 17'h00001;
            lba_q <= lba_q + 48'h000000000001;
            blkCnt_q <= blockEnd ? 8'h00 : blkCnt_q + 8'h01;
        end else if (dataTake) begin
            wordCnt_q <= wordCnt_q + WCW'(1);
        end
    end

    // Media stream: word holds until the media side takes it
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mediaWord_q <= 16'h0000;
            mediaValid_q <= 1'b0;
            mediaLba_q <= 48'h000000000000;
        end else if (dataTake) begin
            mediaWord_q <= writedata[15:0];
            mediaValid_q <= 1'b1;
            // Address rides with its word; lba_q moves on at sector end
            mediaLba_q <= lba_q;
        end else if (mediaReady) begin
            mediaValid_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mediaCommit_q <= 1'b0;
        end else begin
            mediaCommit_q <= sectorEnd && lastSector && !failNow;
        end
    end

    assign mediaWord = mediaWord_q;
    assign mediaValid = mediaValid_q;
    assign mediaLba = mediaLba_q;
    assign mediaCommit = mediaCommit_q;
    assign mediaForce = force_q;

    // Error outcome; other error bits stay zero by construction
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            errSum_q <= 1'b0;
            idnf_q <= 1'b0;
            abort_q <= 1'b0;
            failLba_q <= 48'h000000000000;
        end else if (cmdTake) begin
            errSum_q <= !(writedata[7:0] == multi_write_pkg::OP_MULTI_EXT
                || writedata[7:0] == multi_write_pkg::OP_MULTI_FORCE_EXT);
            idnf_q <= 1'b0;
            abort_q <= !(writedata[7:0] == multi_write_pkg::OP_MULTI_EXT
                || writedata[7:0] == multi_write_pkg::OP_MULTI_FORCE_EXT);
        end else if (failNow) begin
            errSum_q <= 1'b1;
            idnf_q <= mediaFailIdn;
            abort_q <= !mediaFailIdn;
            failLba_q <= lba_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            errHeld_q <= 1'b0;
        end else if (failNow) begin
            errHeld_q <= 1'b1;
        end else if (|pairWr || cmdTake) begin
            errHeld_q <= 1'b0;
        end
    end

    // Busy, device fault and corrected always report clear outside commit
    always_comb begin
        stateByte = 8'h00;
        stateByte[multi_write_pkg::BUSY_POS] = (state_q == multi_write_pkg::ST_COMMIT);
        stateByte[multi_write_pkg::READY_POS] = 1'b1;
        stateByte[multi_write_pkg::DEVFAULT_POS] = 1'b0;
        stateByte[multi_write_pkg::SEEKDONE_POS] = 1'b1;
        stateByte[multi_write_pkg::DATAREQ_POS] = (state_q == multi_write_pkg::ST_XFER);
        stateByte[multi_write_pkg::CORRECTED_POS] = 1'b0;
        stateByte[multi_write_pkg::ERRSUM_POS] = errSum_q;
        faultByte = 8'h00;
        faultByte[multi_write_pkg::IDNF_POS] = idnf_q;
        faultByte[multi_write_pkg::ABORT_POS] = abort_q;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            drive_q <= multi_write_pkg::DRIVE_RESET;
            block_q <= multi_write_pkg::BLOCK_RESET;
            irqMask_q <= multi_write_pkg::MASK_RESET;
        end else if (wrAcc && byteenable[0]) begin
            if (hit(address, multi_write_pkg::OFS_DRIVE)) begin
                drive_q <= writedata[7:0];
            end
            if (hit(address, multi_write_pkg::OFS_BLOCK) && state_q == multi_write_pkg::ST_IDLE) begin
                block_q <= writedata[7:0];
            end
            if (hit(address, multi_write_pkg::OFS_IRQ_MASK)) begin
                irqMask_q <= writedata[2:0];
            end
        end
    end

    // Any paired taskfile register write returns the view to the current halves
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            highSel_q <= 1'b0;
        end else if (wrAcc && byteenable[0] && hit(address, multi_write_pkg::OFS_DEVCTL)) begin
            highSel_q <= writedata[multi_write_pkg::HIGHSEL_POS];
        end else if (|pairWr) begin
            highSel_q <= 1'b0;
        end
    end

    assign blockEvt = blockEnd;
    assign doneEvt = (state_q == multi_write_pkg::ST_COMMIT && commitOk && !failNow) || (cmdTake && !(
        writedata[7:0] == multi_write_pkg::OP_MULTI_EXT || writedata[7:0] == multi_write_pkg::OP_MULTI_FORCE_EXT));
    assign faultEvt = failNow;

    // Read clears status, but an event in the same cycle survives
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irqSts_q <= 3'h0;
        end else begin
            irqSts_q <= ((rdAcc && hit(address, multi_write_pkg::OFS_IRQ_STS)) ? 3'h0 : irqSts_q)
                | {faultEvt, doneEvt, blockEvt};
        end
    end

    assign irq = |(irqSts_q & irqMask_q);

    always_comb begin
        rdMux = 8'h00;
        for (int i = 0; i < 4; i++) begin
            if (hit(address, multi_write_pkg::PAIR_OFS[i])) begin
                rdMux = pairRd[i];
            end
        end
        if (hit(address, multi_write_pkg::OFS_DRIVE)) rdMux = drive_q;
        if (hit(address, multi_write_pkg::OFS_STATE)) rdMux = stateByte;
        if (hit(address, multi_write_pkg::OFS_FAULT)) rdMux = faultByte;
        if (hit(address, multi_write_pkg::OFS_DEVCTL)) rdMux = {highSel_q, 7'h00};
        if (hit(address, multi_write_pkg::OFS_BLOCK)) rdMux = block_q;
        if (hit(address, multi_write_pkg::OFS_IRQ_STS)) rdMux = {5'h00, irqSts_q};
        if (hit(address, multi_write_pkg::OFS_IRQ_MASK)) rdMux = {5'h00, irqMask_q};
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rdDone_q <= 1'b0;
            readdata_q <= 32'h00000000;
        end else begin
            rdDone_q <= rdAcc;
            if (rdAcc) begin
                readdata_q <= {24'h000000, rdMux};
            end
        end
    end

    assign readdata = readdata_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    sequence plainOpcode;
        cmdTake && writedata[7:0] == multi_write_pkg::OP_MULTI_EXT;
    endsequence
    sequence forceOpcode;
        cmdTake && writedata[7:0] == multi_write_pkg::OP_MULTI_FORCE_EXT;
    endsequence
    sequence dataRequested;
        state_q == multi_write_pkg::ST_XFER && stateByte[multi_write_pkg::DATAREQ_POS];
    endsequence

    cmd_start_a: assert property (plainOpcode |=> dataRequested)
        else $error("plain opcode did not open data phase");
    force_start_a: assert property (forceOpcode |=> dataRequested ##0 force_q)
        else $error("forced opcode did not open data phase");
    zero_count_a: assert property (cmdTake && countFull == 16'h0000 && !errSum_q ##0 plainOpcode
        |=> remaining_q == 17'h10000)
        else $error("zero count not taken as full transfer");
    word_pass_a: assert property (dataTake |=> mediaValid_q && mediaWord_q == $past(writedata[15:0]))
        else $error("data word not forwarded");
    block_irq_a: assert property (sectorEnd && blkCnt_q + 8'h01 == blkLen
        |=> irqSts_q[multi_write_pkg::IRQ_BLOCK_POS])
        else $error("block end raised no interrupt");
    mid_block_a: assert property (dataTake && !sectorEnd && !failNow && !doneEvt
        |=> $stable(irqSts_q[multi_write_pkg::IRQ_BLOCK_POS]) || $past(rdAcc))
        else $error("interrupt raised inside a block");
    force_hold_a: assert property (state_q == multi_write_pkg::ST_COMMIT && force_q
        && !mediaCommitDone && !mediaFail
        |=> state_q == multi_write_pkg::ST_COMMIT ##0 stateByte[multi_write_pkg::BUSY_POS])
        else $error("forced write ended before media commit");
    err_low_a: assert property (errHeld_q && !highSel_q && state_q == multi_write_pkg::ST_IDLE
        |-> pairRd[1] == failLba_q[7:0] && pairRd[2] == failLba_q[15:8] && pairRd[3] == failLba_q[23:16])
        else $error("low error address bytes wrong");
    err_high_a: assert property (errHeld_q && highSel_q && state_q == multi_write_pkg::ST_IDLE
        |-> pairRd[1] == failLba_q[31:24] && pairRd[2] == failLba_q[39:32] && pairRd[3] == failLba_q[47:40])
        else $error("high error address bytes wrong");
    fault_bits_a: assert property ((faultByte & 8'heb) == 8'h00 && !stateByte[multi_write_pkg::DEVFAULT_POS]
        && !stateByte[multi_write_pkg::CORRECTED_POS]
        && (state_q != multi_write_pkg::ST_IDLE || !stateByte[multi_write_pkg::BUSY_POS]))
        else $error("unexpected status or error flag");
endmodule

// *** verif/media_model.sv ***
/*
 * Media-side partner: takes words with a periodic stall, answers a commit
 * after a fixed delay, and raises a failure when the bench asks.
 * Assumes one clock shared with the command engine.
 */
module media_model (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic mediaCommit,
    input wire logic failReq,
    input wire logic failIdn,
    output logic mediaReady,
    output logic mediaCommitDone,
    output logic mediaFail,
    output logic mediaFailIdn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] beat_q;
    logic [4:0] wait_q;
    always_ff @(posedge ref_clk) begin
        beat_q <= srst ? 5'h00 : beat_q + 5'h01;
    end
    // One stall in four beats exercises the data write backpressure
    assign mediaReady = beat_q[1:0] != 2'h3;
    // Slow commit so that an early ending status is visible
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wait_q <= 5'h00;
            mediaCommitDone <= 1'b0;
        end else begin
            mediaCommitDone <= wait_q == 5'h01;
            if (mediaCommit) wait_q <= 5'h14;
            else if (wait_q != 5'h00) wait_q <= wait_q - 5'h01;
        end
    end
    // Qualifier toggles outside a failure so it is never left meaningful
    always_ff @(posedge ref_clk) begin
        mediaFail <= !srst && failReq;
        mediaFailIdn <= srst ? 1'b0 : (failReq ? failIdn : ~mediaFailIdn);
    end
endmodule

// *** verif/testbench.sv ***
/*
 * Self-checking bench: Avalon-MM host tasks, command runs for both
 * opcodes, failure readback, interrupt masking and register resets.
 * Assumes the media partner model and a shortened sector length.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin err_count++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
    localparam int SL = 4;
    logic ref_clk = 0, srst = 1, read = 0, write = 0, writeCacheEn = 0, failReq = 0, failIdn = 0;
    logic [5:0] address = 6'h00;
    logic [31:0] writedata = 32'h0, readdata, rd;
    logic waitrequest, irq, mediaValid, mediaReady, mediaCommit, mediaForce;
    logic mediaCommitDone, mediaFail, mediaFailIdn;
    logic [15:0] mediaWord;
    logic [47:0] mediaLba, lba;
    logic [63:0] expQ[$];
    int err_count = 0, checks_done = 0, seed = 49;

    ext_multi_sector_write_cmd #(.SECTOR_LEN(SL)) ext_multi_sector_write_cmd_i (.ref_clk(ref_clk),
        .srst(srst), .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
        .mediaWord(mediaWord), .mediaValid(mediaValid), .mediaReady(mediaReady), .mediaLba(mediaLba),
        .mediaCommit(mediaCommit), .mediaForce(mediaForce), .mediaCommitDone(mediaCommitDone),
        .mediaFail(mediaFail), .mediaFailIdn(mediaFailIdn), .writeCacheEn(writeCacheEn));
    media_model media_model_i (.ref_clk(ref_clk), .srst(srst), .mediaCommit(mediaCommit),
        .failReq(failReq), .failIdn(failIdn), .mediaReady(mediaReady),
        .mediaCommitDone(mediaCommitDone), .mediaFail(mediaFail), .mediaFailIdn(mediaFailIdn));

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    // An unexpected word compares against unknown and is flagged
    always @(posedge ref_clk) begin
        logic [63:0] e;
        if (mediaValid === 1'b1 && mediaReady === 1'b1) begin
            e = expQ.size() > 0 ? expQ.pop_front() : 'x;
            `CHK({mediaLba, mediaWord}, e)
        end
    end

    task print_verdict;
        if (err_count == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task bw(input logic [5:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        address <= a;
        writedata <= d;
        write <= 1'b1;
        @(posedge ref_clk);
        while (waitrequest !== 1'b0) @(posedge ref_clk);
        write <= 1'b0;
    endtask
    task br(input logic [5:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        address <= a;
        read <= 1'b1;
        @(posedge ref_clk);
        while (waitrequest !== 1'b0) @(posedge ref_clk);
        d = readdata;
        read <= 1'b0;
    endtask
    task chkr(input logic [5:0] a, input logic [31:0] e);
        br(a, rd);
        `CHK(rd, e)
    endtask
    task drain;
        int n;
        n = 0;
        while (mediaValid !== 1'b0 && n < 100) begin
            @(posedge ref_clk);
            n++;
        end
        `CHK(mediaValid, 1'b0)
        repeat (3) @(posedge ref_clk);
    endtask
    task wait_idle;
        int n;
        n = 0;
        br(multi_write_pkg::OFS_STATE, rd);
        while (rd[7] !== 1'b0 && n < 100) begin
            br(multi_write_pkg::OFS_STATE, rd);
            n++;
        end
        `CHK(rd[7], 1'b0)
    endtask
    task run(input logic [7:0] op, input int n, input int blk, input int failAt);
        logic [15:0] d;
        int m;
        m = (n == 0) ? 65536 : n;
        bw(multi_write_pkg::OFS_BLOCK, blk);
        bw(multi_write_pkg::PAIR_OFS[0], n >> 8);
        bw(multi_write_pkg::PAIR_OFS[0], n & 255);
        for (int i = 0; i < 3; i++) begin
            bw(multi_write_pkg::PAIR_OFS[i + 1], lba[24 + 8 * i +: 8]);
            bw(multi_write_pkg::PAIR_OFS[i + 1], lba[8 * i +: 8]);
        end
        bw(multi_write_pkg::OFS_COMMAND, op);
        chkr(multi_write_pkg::OFS_STATE, 32'h58);
        for (int s = 0; s < m; s++) begin
            for (int w = 0; w < SL; w++) begin
                if (s * SL + w == failAt) begin
                    drain;
                    failReq <= 1'b1;
                    @(posedge ref_clk);
                    failReq <= 1'b0;
                    repeat (3) @(posedge ref_clk);
                    return;
                end
                d = 16'($random(seed));
                expQ.push_back({lba + 48'(s), d});
                bw(multi_write_pkg::OFS_DATA, {16'h0, d});
            end
            drain;
            // Last sector left unread so block and done stay together
            if (s < m - 1) begin
                br(multi_write_pkg::OFS_IRQ_STS, rd);
                `CHK(rd[0], 1'((s + 1) % blk == 0))
            end
        end
    endtask

    initial begin
        #400000;
        err_count++;
        print_verdict;
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        chkr(multi_write_pkg::OFS_BLOCK, 32'(multi_write_pkg::BLOCK_RESET));
        chkr(multi_write_pkg::OFS_IRQ_MASK, 32'(multi_write_pkg::MASK_RESET));
        chkr(multi_write_pkg::OFS_DRIVE, 32'(multi_write_pkg::DRIVE_RESET));
        chkr(6'h3c, 32'h0);
        chkr(multi_write_pkg::OFS_COMMAND, 32'h0);
        // Start just below a 32-bit carry, interrupts masked
        lba = 48'h12ff_ffff_fffe;
        run(multi_write_pkg::OP_MULTI_EXT, 3, 2, -1);
        wait_idle;
        `CHK(irq, 1'b0)
        chkr(multi_write_pkg::OFS_IRQ_STS, 32'h3);
        chkr(multi_write_pkg::OFS_STATE, 32'h50);
        chkr(multi_write_pkg::OFS_FAULT, 32'h0);
        bw(multi_write_pkg::OFS_IRQ_MASK, 32'h7);
        writeCacheEn <= 1'b1;
        lba = 48'({$random(seed), $random(seed)});
        run(multi_write_pkg::OP_MULTI_EXT, 1, 1, -1);
        chkr(multi_write_pkg::OFS_STATE, 32'h50);
        chkr(multi_write_pkg::OFS_IRQ_STS, 32'h3);
        repeat (30) @(posedge ref_clk);
        lba = 48'({$random(seed), $random(seed)});
        run(multi_write_pkg::OP_MULTI_FORCE_EXT, 2, 1, -1);
        `CHK(mediaForce, 1'b1)
        chkr(multi_write_pkg::OFS_STATE, 32'hd0);
        wait_idle;
        `CHK(irq, 1'b1)
        chkr(multi_write_pkg::OFS_IRQ_STS, 32'h3);
        `CHK(irq, 1'b0)
        writeCacheEn <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            failIdn <= 1'(k);
            lba = 48'({$random(seed), $random(seed)});
            // Plain pass asks for a zero count: a full-size transfer that the failure cuts short
            run(k ? multi_write_pkg::OP_MULTI_FORCE_EXT : multi_write_pkg::OP_MULTI_EXT, k ? 3 : 0, 2, SL + 1);
            expQ.delete();
            chkr(multi_write_pkg::OFS_FAULT, k ? 32'h10 : 32'h04);
            chkr(multi_write_pkg::OFS_STATE, 32'h51);
            chkr(multi_write_pkg::OFS_IRQ_STS, 32'h4);
            lba = lba + 48'h1;
            bw(multi_write_pkg::OFS_DEVCTL, 32'h0);
            for (int i = 0; i < 3; i++) chkr(multi_write_pkg::PAIR_OFS[i + 1], 32'(lba[8 * i +: 8]));
            bw(multi_write_pkg::OFS_DEVCTL, 32'h80);
            for (int i = 0; i < 3; i++) chkr(multi_write_pkg::PAIR_OFS[i + 1], 32'(lba[24 + 8 * i +: 8]));
        end
        // Unknown opcode ends at once as aborted
        bw(multi_write_pkg::OFS_COMMAND, 32'h30);
        chkr(multi_write_pkg::OFS_FAULT, 32'h04);
        chkr(multi_write_pkg::OFS_STATE, 32'h51);
        chkr(multi_write_pkg::OFS_IRQ_STS, 32'h2);
        print_verdict;
    end
endmodule
